// ===== rtl/asd_map.svh
/*
 * Bit positions, reset values and timing counts of the slow-down
 * input block. Included by the package and both design modules.
 */
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH

// Operation mode word
`define ASD_MODE_EN_BIT 8

// Environment word one
`define ASD_ENV_PAT_BIT 4
`define ASD_ENV_TYPE_BIT 5
`define ASD_ENV_POL_BIT 6
`define ASD_ENV_FLT_BIT 26

// Status words
`define ASD_SUB_LATCH_BIT 15
`define ASD_EXT_PIN_BIT 15
`define ASD_ERR_STOP_BIT 10
`define ASD_ERR_W 16
`define ASD_ERR_RST 16'h0000

// Recognition times in reference clock cycles
`define ASD_CNT_W 7
`define ASD_FLT_CYC 7'h50
`define ASD_NOFLT_CYC 7'h02
`define ASD_CNT_ZERO 7'h00
`define ASD_CNT_ONE 7'h01

`endif

// ===== rtl/asd_pkg.sv
/*
 * Types shared by the slow-down input block: axis handshake,
 * profile requests and the control state.
 * Assumes asd_map.svh is on the include path.
 */
`include "asd_map.svh"

package asd_pkg;

    // Signals from the axis pulse engine
    typedef struct packed {
        logic start_cmd;
        logic start_high;
        logic busy;
        logic at_low;
    } asd_axis_t;

    // Requests to the axis pulse engine
    typedef struct packed {
        logic slow_to_low;
        logic stop_req;
        logic start_inhibit;
        logic op_done;
    } asd_prof_t;

    typedef enum logic [2:0] {
        ASD_IDLE,
        ASD_RUN_CONST,
        ASD_RUN_HIGH,
        ASD_STOPPING,
        ASD_BLOCKED
    } asd_state_t;

endpackage : asd_pkg

// ===== rtl/asd_filter.sv
/*
 * Synchroniser, polarity conversion and width filter for the
 * slow-down pin. Assumes the pin may change at any time and that
 * the configuration inputs are steady while the axis runs.
 */
`timescale 1ns/1ps
`include "asd_map.svh"

module asd_filter import asd_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pin and configuration
    input wire logic pin,
    input wire logic pos_logic,
    input wire logic filter_on,
    // Conditioned levels
    output logic active_raw,
    output logic active
);

    logic meta;
    logic sync;
    logic lvl;
    logic [`ASD_CNT_W-1:0] cnt;
    logic [`ASD_CNT_W-1:0] limit;

    // Second flop alone reads the first
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end

    assign lvl = pos_logic ? sync : ~sync;
    assign limit = filter_on ? `ASD_FLT_CYC : `ASD_NOFLT_CYC;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_raw <= 1'b0;
        end else begin
            active_raw <= lvl;
        end
    end

    // A new level must hold for limit cycles in a row; both edges are
    // filtered so a short glitch cannot release a stop either.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt <= `ASD_CNT_ZERO;
            active <= 1'b0;
        end else if (lvl == active) begin
            cnt <= `ASD_CNT_ZERO;
        end else if (cnt == limit - `ASD_CNT_ONE) begin
            cnt <= `ASD_CNT_ZERO;
            active <= lvl;
        end else begin
            cnt <= cnt + `ASD_CNT_ONE;
        end
    end

    chk_filter_width:
    assert property (@(posedge clk_sys) disable iff (rst)
        (active != $past(active))
        |-> ($past(cnt) == $past(limit) - `ASD_CNT_ONE))
    else $error("filtered level changed before its hold time");

endmodule : asd_filter

// ===== rtl/asd_core.sv
/*
 * Slow-down input control of one pulse-train axis: conditions the
 * pin, keeps the latch, steers the speed profile and reports status.
 * Assumes an axis engine that raises busy in the cycle after
 * start_cmd, drops it when the axis stands, and flags at_low while
 * its output speed equals the low start speed.
 */
`timescale 1ns/1ps
`include "asd_map.svh"

module asd_core import asd_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration words
    input wire logic [31:0] environment_one_reg,
    input wire logic [15:0] op_mode,
    // External sensor
    input wire logic slow_down_input,
    // Axis engine and software clear
    input wire asd_axis_t axis,
    input wire logic err_clear,
    // Profile requests
    output asd_prof_t prof,
    // Status
    output logic sub_status_latch,
    output logic slow_down_pin_status,
    output logic [`ASD_ERR_W-1:0] error_cause_reg,
    output logic int_n
);

    logic en;
    logic pat_stop;
    logic latch_type;
    logic pin_act;
    logic act;
    logic live;
    logic latch;
    logic eff;
    logic stop_event;
    asd_state_t state;
    asd_state_t next_state;
    asd_prof_t next_prof;

    asd_filter u_filt (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(slow_down_input),
        .pos_logic(environment_one_reg[`ASD_ENV_POL_BIT]),
        .filter_on(environment_one_reg[`ASD_ENV_FLT_BIT]),
        .active_raw(pin_act),
        .active(act)
    );

    assign en = op_mode[`ASD_MODE_EN_BIT];
    assign pat_stop = environment_one_reg[`ASD_ENV_PAT_BIT];
    assign latch_type = environment_one_reg[`ASD_ENV_TYPE_BIT];
    assign live = en & act;

    // Latch: a fresh assertion wins over the clear at start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch <= 1'b0;
        end else if (!latch_type) begin
            latch <= 1'b0;
        end else if (live) begin
            latch <= 1'b1;
        end else if (axis.start_cmd) begin
            latch <= 1'b0;
        end
    end

    // Latched type also looks at the live level so the first cycle counts
    assign eff = en & (latch_type ? (latch | act) : act);

    assign stop_event = (state == ASD_STOPPING) && !axis.busy;

    always_comb begin
        next_state = state;
        case (state)
            ASD_IDLE, ASD_BLOCKED: begin
                if (axis.start_cmd) begin
                    if (pat_stop && latch_type && live) begin
                        next_state = ASD_BLOCKED;
                    end else if (axis.start_high) begin
                        next_state = ASD_RUN_HIGH;
                    end else begin
                        next_state = ASD_RUN_CONST;
                    end
                end
            end
            ASD_RUN_CONST: begin
                if (!axis.busy) begin
                    next_state = ASD_IDLE;
                end else if (pat_stop && eff) begin
                    next_state = ASD_STOPPING;
                end
            end
            ASD_RUN_HIGH: begin
                if (!axis.busy) begin
                    next_state = ASD_IDLE;
                end else if (pat_stop && eff && axis.at_low) begin
                    next_state = ASD_STOPPING;
                end
            end
            ASD_STOPPING: begin
                if (!axis.busy) begin
                    next_state = ASD_IDLE;
                end
            end
            default: begin
                next_state = ASD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ASD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Constant-speed runs get no slow request until they stop: a non-stopping
    // pattern ignores the input there, a stopping one goes straight
    // to a stop.
    always_comb begin
        next_prof.slow_to_low = 1'b0;
        next_prof.stop_req = 1'b0;
        next_prof.start_inhibit = 1'b0;
        next_prof.op_done = 1'b0;
        case (state)
            ASD_RUN_HIGH: begin
                next_prof.slow_to_low = eff;
            end
            ASD_STOPPING: begin
                next_prof.slow_to_low = 1'b1;
                next_prof.stop_req = axis.busy;
                next_prof.op_done = !axis.busy;
            end
            default: begin
                next_prof.slow_to_low = 1'b0;
            end
        endcase
        next_prof.start_inhibit = (next_state == ASD_BLOCKED);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prof <= '0;
        end else begin
            prof <= next_prof;
        end
    end

    // Stop cause and interrupt; a new stop wins over software's clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            error_cause_reg <= `ASD_ERR_RST;
        end else if (stop_event) begin
            error_cause_reg[`ASD_ERR_STOP_BIT] <= 1'b1;
        end else if (err_clear) begin
            error_cause_reg[`ASD_ERR_STOP_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_n <= 1'b1;
        end else if (stop_event) begin
            int_n <= 1'b0;
        end else if (err_clear) begin
            int_n <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sub_status_latch <= 1'b0;
            slow_down_pin_status <= 1'b0;
        end else begin
            sub_status_latch <= latch;
            slow_down_pin_status <= pin_act;
        end
    end

    chk_latch_cause:
    assert property (@(posedge clk_sys) disable iff (rst)
        $rose(latch) |-> $past(live))
    else $error("latch set without an enabled active input");

    chk_disabled_quiet:
    assert property (@(posedge clk_sys) disable iff (rst)
        (!en && state == ASD_RUN_HIGH) |=> !prof.slow_to_low)
    else $error("slow request while input disabled");

    chk_const_ignore:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_CONST) |=> !prof.slow_to_low)
    else $error("slow request during constant-speed feed");

    chk_level_slow:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_HIGH && !latch_type && live) |=> prof.slow_to_low)
    else $error("high-speed run not slowed by active input");

    chk_level_release:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_HIGH && !latch_type && !act) |=> !prof.slow_to_low)
    else $error("level mode did not re-accelerate on release");

    chk_latch_hold:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_HIGH && latch_type && latch && en)
        |=> prof.slow_to_low)
    else $error("latched mode left the low speed");

    chk_const_stop:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_CONST && axis.busy && pat_stop && live)
        |=> (state == ASD_STOPPING) ##1 prof.stop_req || prof.op_done)
    else $error("constant-speed run not stopped by active input");

    chk_stop_done:
    assert property (@(posedge clk_sys) disable iff (rst)
        stop_event |=> prof.op_done ##1 !prof.op_done)
    else $error("stop did not complete as a single pulse");

    chk_int_cause:
    assert property (@(posedge clk_sys) disable iff (rst)
        prof.op_done |-> (!int_n && error_cause_reg[`ASD_ERR_STOP_BIT]))
    else $error("stop completed without interrupt and cause");

    chk_block_start:
    assert property (@(posedge clk_sys) disable iff (rst)
        (axis.start_cmd && state == ASD_IDLE && pat_stop && latch_type && live)
        |=> (prof.start_inhibit && !prof.op_done))
    else $error("start not blocked by active latched input");

    chk_latch_clear:
    assert property (@(posedge clk_sys) disable iff (rst)
        !latch_type |=> !latch)
    else $error("latch not cleared by level type");

    chk_latch_report:
    assert property (@(posedge clk_sys) disable iff (rst)
        ##1 (sub_status_latch == $past(latch)))
    else $error("latch status bit does not follow the latch");

    chk_pin_report:
    assert property (@(posedge clk_sys) disable iff (rst)
        ##1 (slow_down_pin_status == $past(pin_act)))
    else $error("pin status bit does not follow the input");

    chk_disabled_latch:
    assert property (@(posedge clk_sys) disable iff (rst)
        (!en && !latch) |=> !latch)
    else $error("latch set while input disabled");

    chk_high_stop:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_HIGH && axis.busy && pat_stop && eff
        && axis.at_low) |=> (state == ASD_STOPPING))
    else $error("high-speed run not stopped at low speed");

    chk_stop_request:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_STOPPING && axis.busy) |=> prof.stop_req)
    else $error("no stop request while stopping");

    chk_stop_slow:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_STOPPING) |=> prof.slow_to_low)
    else $error("stopping axis not held at low speed");

    chk_idle_quiet:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_IDLE && !axis.start_cmd)
        |=> (!prof.stop_req && !prof.op_done))
    else $error("stop or completion while idle");

    chk_stop_int:
    assert property (@(posedge clk_sys) disable iff (rst)
        stop_event |=> !int_n)
    else $error("slow-down stop without interrupt");

    chk_int_release:
    assert property (@(posedge clk_sys) disable iff (rst)
        (err_clear && !stop_event) |=> int_n)
    else $error("interrupt not released by clear");

    chk_inhibit_hold:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_BLOCKED && !axis.start_cmd) |=> prof.start_inhibit)
    else $error("blocked start released without a new start");

    chk_run_allowed:
    assert property (@(posedge clk_sys) disable iff (rst)
        (state == ASD_RUN_HIGH || state == ASD_RUN_CONST)
        |=> !prof.start_inhibit)
    else $error("start inhibited during a run");

    chk_start_clear:
    assert property (@(posedge clk_sys) disable iff (rst)
        (axis.start_cmd && !live) |=> !latch)
    else $error("latch not cleared at start with input inactive");

    chk_latch_set:
    assert property (@(posedge clk_sys) disable iff (rst)
        (latch_type && live) |=> latch)
    else $error("latched type did not latch the input");

    chk_stop_cause:
    assert property (@(posedge clk_sys) disable iff (rst)
        stop_event |=> error_cause_reg[`ASD_ERR_STOP_BIT])
    else $error("slow-down stop without cause bit");

endmodule : asd_core

// ===== tb/asd_sensor.sv
/*
 * Behavioural slow-down sensor standing on the far side of the pin.
 * Assumes the bench drives active on clock edges and feeds it the
 * same polarity bit that the block is configured with.
 */
`timescale 1ns/1ps

module asd_sensor (
    // Control from the bench
    input wire logic active,
    input wire logic pos_logic,
    // Pin towards the block
    output logic pin
);
    // A negative-logic sensor pulls the pin low while it is active
    assign pin = pos_logic ? active : ~active;
endmodule : asd_sensor

// ===== tb/axis_slowdown_input_control_bench.sv
/*
 * Self-checking bench of the slow-down input block with a sensor
 * model and a crude axis engine that answers profile requests.
 * Assumes asd_map.svh on the include path and a 200 MHz clock.
 */
`timescale 1ns/1ps
`include "asd_map.svh"

module axis_slowdown_input_control_bench import asd_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] env;
    logic [15:0] op_mode;
    logic sens_on, pin, err_clear, move_ok, halt;
    logic start_cmd, start_high, busy, at_low;
    asd_axis_t axis;
    asd_prof_t prof;
    logic sub_latch, pin_stat, int_n;
    logic [15:0] err;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int done_cnt = 0;
    int done_base = 0;

    assign axis = {start_cmd, start_high, busy, at_low};

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    asd_sensor sens_u (.active(sens_on), .pos_logic(env[`ASD_ENV_POL_BIT]),
        .pin(pin));

    asd_core dut_u (.clk_sys(clk_sys), .rst(rst),
        .environment_one_reg(env), .op_mode(op_mode),
        .slow_down_input(pin), .axis(axis), .err_clear(err_clear),
        .prof(prof), .sub_status_latch(sub_latch),
        .slow_down_pin_status(pin_stat), .error_cause_reg(err),
        .int_n(int_n));

    // Engine reaches the low speed one cycle after the request
    always @(posedge clk_sys) begin
        if (rst || prof.stop_req || halt) begin
            busy <= 1'b0;
        end else if (start_cmd && move_ok) begin
            busy <= 1'b1;
        end
        at_low <= prof.slow_to_low;
        if (prof.op_done) begin
            done_cnt <= done_cnt + 1;
        end
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic cfg(input logic pat, typ, pol, flt);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`ASD_ENV_PAT_BIT] = pat;
        v[`ASD_ENV_TYPE_BIT] = typ;
        v[`ASD_ENV_POL_BIT] = pol;
        v[`ASD_ENV_FLT_BIT] = flt;
        // Level type first: the pin path glitches while polarity flips
        v[`ASD_ENV_TYPE_BIT] = 1'b0;
        env <= v;
        tick(6);
        v[`ASD_ENV_TYPE_BIT] = typ;
        env <= v;
        tick(2);
    endtask : cfg

    task automatic start(input logic hi);
        start_cmd <= 1'b1;
        start_high <= hi;
        tick(1);
        start_cmd <= 1'b0;
        tick(1);
    endtask : start

    task automatic stop_axis;
        halt <= 1'b1;
        tick(2);
        halt <= 1'b0;
        tick(6);
    endtask : stop_axis

    initial begin
        env = 32'h0000_0000;
        op_mode = 16'h0000;
        {start_cmd, start_high} = 2'h0;
        {sens_on, err_clear, halt} = 3'h0;
        move_ok = 1'b1;
        tick(8);
        rst <= 1'b0;
        cfg(1'b0, 1'b0, 1'b1, 1'b0);
        start(1'b1);
        sens_on <= 1'b1;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b0);
        chk_bit(pin_stat, 1'b1);
        op_mode <= 16'h0100;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b1);
        sens_on <= 1'b0;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b0);
        chk_bit(sub_latch, 1'b0);
        stop_axis();
        start(1'b0);
        sens_on <= 1'b1;
        tick(8);
        chk_bit(prof.slow_to_low | prof.stop_req, 1'b0);
        stop_axis();
        start(1'b1);
        tick(4);
        chk_bit(prof.slow_to_low, 1'b1);
        sens_on <= 1'b0;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b0);
        stop_axis();
        cfg(1'b0, 1'b1, 1'b0, 1'b0);
        chk_bit(pin_stat, 1'b0);
        start(1'b1);
        sens_on <= 1'b1;
        tick(8);
        sens_on <= 1'b0;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b1);
        chk_bit(sub_latch, 1'b1);
        stop_axis();
        start(1'b1);
        tick(2);
        chk_bit(sub_latch, 1'b0);
        stop_axis();
        sens_on <= 1'b1;
        tick(8);
        start(1'b1);
        sens_on <= 1'b0;
        tick(8);
        chk_bit(prof.slow_to_low, 1'b1);
        cfg(1'b0, 1'b0, 1'b0, 1'b0);
        chk_bit(sub_latch, 1'b0);
        stop_axis();
        // Stopping pattern with both input types, constant and high-speed starts
        for (int t = 0; t < 4; t++) begin
            cfg(1'b1, t[1], 1'b1, 1'b0);
            done_base = done_cnt;
            start(t[0]);
            sens_on <= 1'b1;
            tick(14);
            chk_bit(axis.busy, 1'b0);
            chk_word(16'(done_cnt - done_base), 16'h0001);
            chk_bit(int_n, 1'b0);
            chk_word(err, 16'h0400);
            err_clear <= 1'b1;
            tick(1);
            err_clear <= 1'b0;
            sens_on <= 1'b0;
            tick(8);
            chk_bit(int_n, 1'b1);
            chk_word(err, 16'h0000);
        end
        done_base = done_cnt;
        sens_on <= 1'b1;
        tick(8);
        move_ok <= 1'b0;
        start(1'b0);
        tick(8);
        chk_bit(prof.start_inhibit, 1'b1);
        chk_word(16'(done_cnt - done_base), 16'h0000);
        sens_on <= 1'b0;
        cfg(1'b0, 1'b0, 1'b1, 1'b0);
        cfg(1'b0, 1'b1, 1'b1, 1'b0);
        sens_on <= 1'b1;
        tick(1);
        sens_on <= 1'b0;
        tick(8);
        chk_bit(sub_latch, 1'b0);
        sens_on <= 1'b1;
        tick(3);
        sens_on <= 1'b0;
        tick(6);
        chk_bit(sub_latch, 1'b1);
        cfg(1'b0, 1'b0, 1'b1, 1'b1);
        cfg(1'b0, 1'b1, 1'b1, 1'b1);
        sens_on <= 1'b1;
        tick(79);
        sens_on <= 1'b0;
        tick(90);
        chk_bit(sub_latch, 1'b0);
        sens_on <= 1'b1;
        tick(86);
        chk_bit(sub_latch, 1'b1);
        end_of_test();
    end
endmodule : axis_slowdown_input_control_bench
